// ### src/mmo_pkg.sv
// Constants and types shared by the meter output block
package mmo_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    // Terminal mode values
    localparam logic MODE_ANALOG = 1'h0;
    localparam logic MODE_PULSE = 1'h1;
    // Monitored item codes
    localparam logic [3:0] ITEM_FREQ_PRE = 4'h0;
    localparam logic [3:0] ITEM_FREQ_POST = 4'h1;
    localparam logic [3:0] ITEM_CURRENT = 4'h2;
    localparam logic [3:0] ITEM_VOLTAGE = 4'h3;
    localparam logic [3:0] ITEM_TORQUE = 4'h4;
    localparam logic [3:0] ITEM_LOAD = 4'h5;
    localparam logic [3:0] ITEM_POWER = 4'h6;
    localparam logic [3:0] ITEM_PID = 4'h7;
    localparam logic [3:0] ITEM_DC_LINK = 4'h8;
    localparam int ITEM_COUNT = 9;
    // Full-scale voltages in volts, by voltage class
    localparam logic [15:0] FS_VOUT_LOW = 16'h00FA;
    localparam logic [15:0] FS_VOUT_HIGH = 16'h01F4;
    localparam logic [15:0] FS_DCL_LOW = 16'h01F4;
    localparam logic [15:0] FS_DCL_HIGH = 16'h03E8;
    // Gain and setting ranges in percent; pulse rates in pulses per second
    localparam logic [7:0] GAIN_MAX = 8'hC8;
    localparam logic [12:0] RATE_MIN = 13'h012C;
    localparam logic [12:0] RATE_MAX = 13'h1770;
    localparam logic [12:0] RATE_FIXED = 13'h0A6E;
    // Level scale: 100 % quantity at 100 % gain gives 100*256
    localparam int LEVEL_SHIFT = 8;
    localparam logic [15:0] DUTY_FULL = 16'hC800;
    // Phase accumulator wraps at one second of clock cycles, so once per pulse
    localparam logic [26:0] PHASE_WRAP = 27'(CLK_HZ);
    localparam logic [26:0] PHASE_HALF = 27'(CLK_HZ / 2);
    localparam logic [26:0] DUTY_STEP = 27'(CLK_HZ / 51200);
    // Pulse high level in millivolts
    localparam int PULSE_HIGH_MV = 15600;
    localparam int DIV_STEPS = 16;
    localparam logic [4:0] DIV_LAST = 5'(DIV_STEPS - 1);
    typedef enum logic {JOB_ANALOG, JOB_PULSE} mmo_job_e;
endpackage

// ### src/mmo_div_if.sv
// Handshake between the sequencer and the shared divider
`timescale 1ns/1ps
interface mmo_div_if;
    logic start;
    logic [47:0] num;
    logic [15:0] den;
    logic done;
    logic [15:0] quot;
    modport master (output start, output num, output den,
        input done, input quot);
    modport slave (input start, input num, input den,
        output done, output quot);
endinterface

// ### src/mmo_div.sv
// Serial saturating divider, 16-bit quotient
`timescale 1ns/1ps
module mmo_div (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Request and answer
    mmo_div_if.slave dv
);
    import mmo_pkg::*;

    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic [15:0] rem_r, rem_nxt;
    logic [15:0] low_r, low_nxt;
    logic [15:0] quot_r, quot_nxt;
    logic [15:0] den_r, den_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [16:0] trial;

    always_comb begin
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        rem_nxt = rem_r;
        low_nxt = low_r;
        quot_nxt = quot_r;
        den_nxt = den_r;
        cnt_nxt = cnt_r;
        trial = {rem_r, low_r[15]};
        if (!busy_r && dv.start) begin
            den_nxt = dv.den;
            if (dv.den == 16'h0000) begin
                quot_nxt = 16'h0000;
                done_nxt = 1'b1;
            end else if (dv.num[47:16] >= {16'h0000, dv.den}) begin
                // Quotient does not fit: saturate
                quot_nxt = 16'hFFFF;
                done_nxt = 1'b1;
            end else begin
                rem_nxt = dv.num[31:16];
                low_nxt = dv.num[15:0];
                cnt_nxt = 5'h00;
                busy_nxt = 1'b1;
            end
        end else if (busy_r) begin
            low_nxt = {low_r[14:0], 1'b0};
            if (trial >= {1'b0, den_r}) begin
                rem_nxt = 16'(trial - {1'b0, den_r});
                quot_nxt = {quot_r[14:0], 1'b1};
            end else begin
                rem_nxt = trial[15:0];
                quot_nxt = {quot_r[14:0], 1'b0};
            end
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == DIV_LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            rem_r <= 16'h0000;
            low_r <= 16'h0000;
            quot_r <= 16'h0000;
            den_r <= 16'h0000;
            cnt_r <= 5'h00;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            rem_r <= rem_nxt;
            low_r <= low_nxt;
            quot_r <= quot_nxt;
            den_r <= den_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign dv.done = done_r;
    assign dv.quot = quot_r;

    a_div_bounded: assert property (@(posedge clk)
        disable iff (srst)
        (!busy_r && dv.start) |-> ##[1:17] done_r)
        else $error("divider did not finish in time");
endmodule

// ### src/mmo_meter_top.sv
// Meter output terminal: analog level or pulse train of a monitored item
`timescale 1ns/1ps
module mmo_meter_top (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Settings
    input wire logic meter_terminal_mode_select,
    input wire logic [7:0] analog_meter_gain,
    input wire logic [3:0] analog_meter_item_select,
    input wire logic [12:0] pulse_full_scale_rate,
    input wire logic [7:0] pulse_average_voltage_setting,
    input wire logic [3:0] pulse_meter_item_select,
    input wire logic voltage_class_high,
    // Monitored quantities, indexed by item code
    input wire logic [15:0] mon_value [mmo_pkg::ITEM_COUNT],
    // Full-scale references
    input wire logic [15:0] max_output_freq,
    input wire logic [15:0] rated_current,
    input wire logic [15:0] rated_torque,
    input wire logic [15:0] rated_load,
    input wire logic [15:0] rated_power,
    input wire logic [15:0] pid_full_scale,
    // Terminal outputs
    output logic [15:0] analog_level,
    output logic meter_pulse_out,
    output logic [15:0] pulse_rate_now,
    output logic [15:0] pulse_duty_level
);
    import mmo_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Item decode, shared by both selectors

    function automatic logic [15:0] full_scale(input logic [3:0] sel);
        case (sel)
            ITEM_FREQ_PRE, ITEM_FREQ_POST: full_scale = max_output_freq;
            ITEM_CURRENT: full_scale = {rated_current[14:0], 1'b0};
            ITEM_VOLTAGE:
                full_scale = voltage_class_high ? FS_VOUT_HIGH : FS_VOUT_LOW;
            ITEM_TORQUE: full_scale = {rated_torque[14:0], 1'b0};
            ITEM_LOAD: full_scale = {rated_load[14:0], 1'b0};
            ITEM_POWER: full_scale = {rated_power[14:0], 1'b0};
            ITEM_PID: full_scale = pid_full_scale;
            ITEM_DC_LINK:
                full_scale = voltage_class_high ? FS_DCL_HIGH : FS_DCL_LOW;
            default: full_scale = 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] item_value(input logic [3:0] sel);
        if (sel <= ITEM_DC_LINK) begin
            item_value = mon_value[sel];
        end else begin
            item_value = 16'h0000;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Settings clamped into range

    logic [7:0] gain_c, avg_c;
    logic [12:0] rate_c;
    logic duty_mode;

    always_comb begin
        gain_c = (analog_meter_gain > GAIN_MAX) ? GAIN_MAX :
            analog_meter_gain;
        avg_c = (pulse_average_voltage_setting > GAIN_MAX) ? GAIN_MAX :
            pulse_average_voltage_setting;
        if (pulse_full_scale_rate < RATE_MIN) begin
            rate_c = RATE_MIN;
        end else if (pulse_full_scale_rate > RATE_MAX) begin
            rate_c = RATE_MAX;
        end else begin
            rate_c = pulse_full_scale_rate;
        end
        duty_mode = (avg_c != 8'h00);
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: alternates analog and pulse jobs on the shared divider

    mmo_div_if dv ();

    mmo_div u_div (
        .clk(clk),
        .srst(srst),
        .dv(dv)
    );

    mmo_job_e job_r, job_nxt;
    logic wait_r, wait_nxt;
    logic [15:0] level_r, level_nxt;
    logic [15:0] rate_r, rate_nxt;
    logic [15:0] duty_r, duty_nxt;
    logic [15:0] a_q, p_q;

    always_comb begin
        a_q = item_value(analog_meter_item_select);
        p_q = item_value(pulse_meter_item_select);
        job_nxt = job_r;
        wait_nxt = wait_r;
        level_nxt = level_r;
        rate_nxt = rate_r;
        duty_nxt = duty_r;
        dv.start = !wait_r;
        dv.num = 48'h0;
        dv.den = 16'h0000;
        case (job_r)
            JOB_ANALOG: begin
                dv.num = (48'(a_q) * 48'(gain_c)) << LEVEL_SHIFT;
                dv.den = full_scale(analog_meter_item_select);
            end
            JOB_PULSE: begin
                dv.den = full_scale(pulse_meter_item_select);
                if (duty_mode) begin
                    dv.num = (48'(p_q) * 48'(avg_c)) << LEVEL_SHIFT;
                end else begin
                    dv.num = 48'(p_q) * 48'(rate_c);
                end
            end
            default: begin
                dv.num = 48'h0;
            end
        endcase
        if (!wait_r) begin
            wait_nxt = 1'b1;
        end else if (dv.done) begin
            wait_nxt = 1'b0;
            if (job_r == JOB_ANALOG) begin
                level_nxt = dv.quot;
                job_nxt = JOB_PULSE;
            end else begin
                job_nxt = JOB_ANALOG;
                if (duty_mode) begin
                    rate_nxt = {3'h0, RATE_FIXED};
                    duty_nxt = (dv.quot > DUTY_FULL) ? DUTY_FULL : dv.quot;
                end else begin
                    duty_nxt = 16'h0000;
                    rate_nxt = (dv.quot > {3'h0, rate_c}) ?
                        {3'h0, rate_c} : dv.quot;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            job_r <= JOB_ANALOG;
            wait_r <= 1'b0;
            level_r <= 16'h0000;
            rate_r <= 16'h0000;
            duty_r <= 16'h0000;
        end else begin
            job_r <= job_nxt;
            wait_r <= wait_nxt;
            level_r <= level_nxt;
            rate_r <= rate_nxt;
            duty_r <= duty_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse train: phase accumulator advancing by the rate each clock

    logic [26:0] phase_r, phase_nxt;
    logic [27:0] phase_sum;
    logic [26:0] duty_thresh;
    logic pulse_r, pulse_nxt;
    logic [15:0] out_level_r, out_level_nxt;

    always_comb begin
        phase_sum = {1'b0, phase_r} + 28'(rate_r);
        if (phase_sum >= {1'b0, PHASE_WRAP}) begin
            phase_nxt = 27'(phase_sum - {1'b0, PHASE_WRAP});
        end else begin
            phase_nxt = phase_sum[26:0];
        end
        // High time over period sets the average of the 15.6 V level
        duty_thresh = 27'(duty_r * DUTY_STEP);
        pulse_nxt = 1'b0;
        if (meter_terminal_mode_select == MODE_PULSE && rate_r != 0) begin
            if (duty_mode) begin
                pulse_nxt = (phase_r < duty_thresh);
            end else begin
                pulse_nxt = (phase_r < PHASE_HALF);
            end
        end
        out_level_nxt = (meter_terminal_mode_select == MODE_ANALOG) ?
            level_r : 16'h0000;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_r <= 27'h0;
            pulse_r <= 1'b0;
            out_level_r <= 16'h0000;
        end else begin
            phase_r <= phase_nxt;
            pulse_r <= pulse_nxt;
            out_level_r <= out_level_nxt;
        end
    end

    assign analog_level = out_level_r;
    assign meter_pulse_out = pulse_r;
    assign pulse_rate_now = rate_r;
    assign pulse_duty_level = duty_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_analog_mode_quiet: assert property (@(posedge clk)
        disable iff (srst)
        $past(meter_terminal_mode_select) == MODE_ANALOG
        |-> !meter_pulse_out)
        else $error("pulse seen in analog mode");

    a_pulse_mode_level: assert property (@(posedge clk)
        disable iff (srst)
        $past(meter_terminal_mode_select) == MODE_PULSE
        |-> analog_level == 16'h0000)
        else $error("analog level seen in pulse mode");

    a_level_follows: assert property (@(posedge clk)
        disable iff (srst)
        dv.done && job_r == JOB_ANALOG |=> level_r == $past(dv.quot))
        else $error("analog level not loaded from result");

    a_rate_capped: assert property (@(posedge clk)
        disable iff (srst)
        !duty_mode && dv.done && job_r == JOB_PULSE
        |=> rate_r <= {3'h0, $past(rate_c)})
        else $error("variable rate above full-scale rate");

    a_fixed_rate: assert property (@(posedge clk)
        disable iff (srst)
        duty_mode && dv.done && job_r == JOB_PULSE
        |=> rate_r == {3'h0, RATE_FIXED})
        else $error("duty mode rate not fixed");

    a_duty_limit: assert property (@(posedge clk)
        disable iff (srst)
        duty_r <= DUTY_FULL)
        else $error("duty above full period");

    a_rate_range: assert property (@(posedge clk)
        disable iff (srst)
        rate_c >= RATE_MIN && rate_c <= RATE_MAX
        && (pulse_full_scale_rate < RATE_MIN
        || pulse_full_scale_rate > RATE_MAX
        || rate_c == pulse_full_scale_rate))
        else $error("full-scale rate outside range or altered");

    a_jobs_alternate: assert property (@(posedge clk)
        disable iff (srst)
        dv.done |=> job_r != $past(job_r))
        else $error("jobs did not alternate");

    a_bad_item_zero: assert property (@(posedge clk)
        disable iff (srst)
        dv.done && job_r == JOB_ANALOG
        && analog_meter_item_select > ITEM_DC_LINK
        && $past(analog_meter_item_select, 20) == analog_meter_item_select
        |=> level_r == 16'h0000)
        else $error("unknown item gave a level");
endmodule

// ### verification/mmo_pulse_meter.sv
// Pulse counter model that times the meter pulse train
`timescale 1ns/1ps
module mmo_pulse_meter (
    // Clock
    input wire logic clk,
    // Pulse input
    input wire logic pulse_in,
    // Measurements
    output logic [31:0] n_rise,
    output logic [31:0] n_fall,
    output logic [31:0] high_cyc,
    output logic [31:0] period_cyc,
    output logic [31:0] avg_mv
);
    logic prev = 1'b0;
    logic [31:0] t_per = 32'h0;
    initial begin
        n_rise = 32'h0;
        n_fall = 32'h0;
        high_cyc = 32'h0;
        period_cyc = 32'h0;
        avg_mv = 32'h0;
    end
    // Times every high phase and full period from rising edge to edge
    always @(posedge clk) begin
        prev <= pulse_in;
        t_per <= t_per + 32'h1;
        if (pulse_in && !prev) begin
            n_rise <= n_rise + 32'h1;
            period_cyc <= t_per;
            t_per <= 32'h1;
            if (t_per != 0) begin
                avg_mv <= 32'(64'd15600 * high_cyc / t_per);
            end
        end
        if (!pulse_in && prev) begin
            n_fall <= n_fall + 32'h1;
            high_cyc <= t_per;
        end
    end
endmodule

// ### verification/mmo_meter_top_tb.sv
// Self-checking bench for the meter output terminal
`timescale 1ns/1ps
module mmo_meter_top_tb;
    import mmo_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic mode = 1'b0;
    logic [7:0] gain = 8'h00;
    logic [3:0] a_item = 4'h0;
    logic [12:0] fs_rate = 13'h0BB8;
    logic [7:0] avs = 8'h00;
    logic [3:0] p_item = 4'h0;
    logic vclass = 1'b0;
    logic [15:0] mon [ITEM_COUNT];
    logic [15:0] ref_v [6];
    logic [15:0] a_lvl, p_rate, p_duty;
    logic p_out;
    logic [31:0] n_rise, n_fall, high_cyc, period_cyc, avg_mv;
    int err_total = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    mmo_meter_top i_mmo_meter_top (.clk(clk), .srst(srst),
        .meter_terminal_mode_select(mode), .analog_meter_gain(gain),
        .analog_meter_item_select(a_item), .pulse_full_scale_rate(fs_rate),
        .pulse_average_voltage_setting(avs), .pulse_meter_item_select(p_item),
        .voltage_class_high(vclass), .mon_value(mon),
        .max_output_freq(ref_v[0]), .rated_current(ref_v[1]),
        .rated_torque(ref_v[2]), .rated_load(ref_v[3]),
        .rated_power(ref_v[4]), .pid_full_scale(ref_v[5]),
        .analog_level(a_lvl), .meter_pulse_out(p_out),
        .pulse_rate_now(p_rate), .pulse_duty_level(p_duty));
    mmo_pulse_meter i_mmo_pulse_meter (.clk(clk), .pulse_in(p_out),
        .n_rise(n_rise), .n_fall(n_fall), .high_cyc(high_cyc),
        .period_cyc(period_cyc), .avg_mv(avg_mv));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] fs_of(input logic [3:0] it);
        case (it)
            ITEM_FREQ_PRE, ITEM_FREQ_POST: fs_of = 32'(ref_v[0]);
            ITEM_CURRENT: fs_of = 32'(ref_v[1]) * 2;
            ITEM_VOLTAGE: fs_of = 32'(vclass ? FS_VOUT_HIGH : FS_VOUT_LOW);
            ITEM_TORQUE: fs_of = 32'(ref_v[2]) * 2;
            ITEM_LOAD: fs_of = 32'(ref_v[3]) * 2;
            ITEM_POWER: fs_of = 32'(ref_v[4]) * 2;
            ITEM_PID: fs_of = 32'(ref_v[5]);
            ITEM_DC_LINK: fs_of = 32'(vclass ? FS_DCL_HIGH : FS_DCL_LOW);
            default: fs_of = 32'h0;
        endcase
    endfunction
    function automatic logic [31:0] scale(input logic [63:0] num,
        input logic [31:0] fs, input logic [31:0] cap);
        logic [63:0] v;
        v = (fs == 0) ? 64'h0 : num / fs;
        scale = (v > cap) ? cap : v[31:0];
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog at about 80k cycles; the run needs about 50k
    initial begin
        #800_000;
        err_total++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] q;
        logic [31:0] g, s, r, f0, e;
        foreach (mon[j]) mon[j] = 16'h0000;
        foreach (ref_v[j]) ref_v[j] = 16'h03E8;
        void'($urandom(32'h1120));
        repeat (16) @(negedge clk);
        check("reset pulse", p_out, 32'h0);
        check("reset level", a_lvl, 32'h0);
        check("reset rate duty", {p_rate, p_duty}, 32'h0);
        srst = 1'b0;
        for (int k = 0; k < 48; k++) begin
            vclass = 1'($urandom);
            foreach (ref_v[j]) ref_v[j] = 16'(100 + $urandom % 4000);
            foreach (mon[j]) mon[j] = 16'($urandom % (k < 24 ? 1200 : 9000));
            mode = 1'(k);
            gain = (k == 2) ? 8'hFA : 8'($urandom % 201);
            a_item = (k == 4) ? 4'hC : 4'($urandom % 9);
            p_item = (k == 9) ? 4'hA : 4'($urandom % 9);
            fs_rate = (k == 3) ? 13'h0064 : (k == 7) ? 13'h1B58 :
                13'(300 + $urandom % 5701);
            avs = (k % 4 == 3) ? 8'h00 : (k == 5) ? 8'hFF :
                8'(1 + $urandom % 200);
            repeat (80) @(negedge clk);
            g = (gain > GAIN_MAX) ? 32'(GAIN_MAX) : 32'(gain);
            s = (avs > GAIN_MAX) ? 32'(GAIN_MAX) : 32'(avs);
            r = (fs_rate < RATE_MIN) ? 32'(RATE_MIN) :
                (fs_rate > RATE_MAX) ? 32'(RATE_MAX) : 32'(fs_rate);
            if (!mode) begin
                q = (a_item < 9) ? 64'(mon[a_item]) : 64'h0;
                check("analog", a_lvl, scale(q * g * 256, fs_of(a_item),
                    32'hFFFF));
                check("pulse idle", p_out, 32'h0);
            end else begin
                check("analog idle", a_lvl, 32'h0);
                q = (p_item < 9) ? 64'(mon[p_item]) : 64'h0;
                if (s == 0) begin
                    check("rate", p_rate, scale(q * r, fs_of(p_item),
                        r));
                    check("duty idle", p_duty, 32'h0);
                end else begin
                    check("fixed rate", p_rate, 32'(RATE_FIXED));
                    check("duty", p_duty, scale(q * s * 256, fs_of(p_item),
                        32'(DUTY_FULL)));
                end
            end
        end
        // Full-scale item, variable rate at the top rate, phase from zero
        mode = 1'b1;
        p_item = ITEM_FREQ_PRE;
        mon[0] = ref_v[0];
        fs_rate = RATE_MAX;
        avs = 8'h00;
        srst = 1'b1;
        repeat (2) @(negedge clk);
        check("mid reset pulse", p_out, 32'h0);
        check("mid reset rate", p_rate, 32'h0);
        srst = 1'b0;
        f0 = n_fall;
        for (int t = 0; t < 20000 && n_fall < f0 + 1; t++) @(negedge clk);
        check("fall seen", 32'(n_fall > f0), 32'h1);
        check("top rate", p_rate, 32'(RATE_MAX));
        e = 32'(PHASE_HALF / RATE_MAX);
        check("half high", 32'(high_cyc + 2 - e <= 4), 32'h1);
        // Duty mode at setting 100 gives half of the 15.6 V level
        avs = 8'h64;
        srst = 1'b1;
        repeat (2) @(negedge clk);
        check("mid reset duty", p_duty, 32'h0);
        srst = 1'b0;
        f0 = n_rise;
        for (int t = 0; t < 40000 && n_rise < f0 + 2; t++) @(negedge clk);
        check("rises seen", 32'(n_rise >= f0 + 2), 32'h1);
        check("duty at 100", p_duty, 32'h6400);
        e = 32'(PHASE_WRAP / RATE_FIXED);
        check("period", 32'(period_cyc + 2 - e <= 4), 32'h1);
        e = PULSE_HIGH_MV * 25600 / DUTY_FULL;
        check("average mv", 32'(avg_mv + 20 - e <= 40), 32'h1);
        end_of_test();
    end
endmodule
